// [logic/pob_bank.sv]
// Peripheral module-off register bank for both cores, with per-peripheral resets
// and clock enables for the register-1 peripherals. Assumes one 100 MHz clock and an Avalon-MM master.
//
// Implementation choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module pob_bank (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [5:0]  address_in,
  input  wire logic        read_in,
  input  wire logic        write_in,
  input  wire logic [31:0] writedata_in,
  input  wire logic [3:0]  byteenable_in,
  output logic      [31:0] readdata_out,
  output logic      [1:0]  response_out,
  output logic             waitrequest_out,
  output logic      [15:0] master_off_1_out,
  output logic      [15:0] master_off_2_out,
  output logic      [15:0] master_off_3_out,
  output logic      [15:0] master_off_4_out,
  output logic      [15:0] master_off_6_out,
  output logic      [15:0] master_off_7_out,
  output logic      [15:0] master_off_8_out,
  output logic      [15:0] slave_off_1_out,
  output logic      [15:0] slave_off_2_out,
  output logic      [15:0] slave_off_4_out,
  output logic      [15:0] slave_off_6_out,
  output logic      [15:0] slave_off_7_out,
  output logic      [15:0] slave_off_8_out,
  output logic      [15:0] master_clk_en_1_out,
  output logic      [15:0] slave_clk_en_1_out
);

  logic [15:0] m1_q, m2_q, m3_q, m4_q, m6_q, m7_q, m8_q;
  logic [15:0] s1_q, s2_q, s4_q, s6_q, s7_q, s8_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic [1:0]  resp_q;
  logic        req;
  logic        wr_go;
  logic [15:0] wmask;
  logic [15:0] wval;
  logic [15:0] sel_mask;
  logic [15:0] sel_val;

  // Every access takes one wait cycle so read data come from a flop
  assign req             = read_in | write_in;
  assign waitrequest_out = req & ~ack_q;
  assign wr_go           = write_in & ack_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // Byte lanes 0 and 1 carry the 16-bit register
  assign wmask = {{8{byteenable_in[1]}}, {8{byteenable_in[0]}}};
  assign wval  = writedata_in[15:0];

  // Address decode: mask of implemented bits and present value
  always_comb begin
    sel_mask = 16'h0000;
    sel_val  = 16'h0000;
    unique case (address_in)
      pob_pkg::MASTER_OFF_1: begin sel_mask = pob_pkg::M1_MASK; sel_val = m1_q; end // R12
      pob_pkg::MASTER_OFF_2: begin sel_mask = pob_pkg::M2_MASK; sel_val = m2_q; end
      pob_pkg::MASTER_OFF_3: begin sel_mask = pob_pkg::M3_MASK; sel_val = m3_q; end
      pob_pkg::MASTER_OFF_4: begin sel_mask = pob_pkg::M4_MASK; sel_val = m4_q; end
      pob_pkg::MASTER_OFF_6: begin sel_mask = pob_pkg::M6_MASK; sel_val = m6_q; end
      pob_pkg::MASTER_OFF_7: begin sel_mask = pob_pkg::M7_MASK; sel_val = m7_q; end
      pob_pkg::MASTER_OFF_8: begin sel_mask = pob_pkg::M8_MASK; sel_val = m8_q; end
      pob_pkg::SLAVE_OFF_1:  begin sel_mask = pob_pkg::S1_MASK; sel_val = s1_q; end // R1 R2
      pob_pkg::SLAVE_OFF_2:  begin sel_mask = pob_pkg::S2_MASK; sel_val = s2_q; end // R3
      pob_pkg::SLAVE_OFF_4:  begin sel_mask = pob_pkg::S4_MASK; sel_val = s4_q; end // R4
      pob_pkg::SLAVE_OFF_6:  begin sel_mask = pob_pkg::S6_MASK; sel_val = s6_q; end // R5
      pob_pkg::SLAVE_OFF_7:  begin sel_mask = pob_pkg::S7_MASK; sel_val = s7_q; end // R6 R7
      pob_pkg::SLAVE_OFF_8:  begin sel_mask = pob_pkg::S8_MASK; sel_val = s8_q; end // R8 R9
      default: begin sel_mask = 16'h0000; sel_val = 16'h0000; end
    endcase
  end

  // Merge of a write into one register; unimplemented bits forced to zero
  function automatic logic [15:0] merge(input logic [15:0] old_v,
                                        input logic [15:0] impl,
                                        input logic [15:0] lanes,
                                        input logic [15:0] val);
    merge = ((val & lanes) | (old_v & ~lanes)) & impl;
  endfunction : merge

  // Master registers; a write lands at the edge where waitrequest is low
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      m1_q <= pob_pkg::RESET_VAL; // R11
      m2_q <= pob_pkg::RESET_VAL;
      m3_q <= pob_pkg::RESET_VAL;
      m4_q <= pob_pkg::RESET_VAL;
      m6_q <= pob_pkg::RESET_VAL;
      m7_q <= pob_pkg::RESET_VAL;
      m8_q <= pob_pkg::RESET_VAL;
    end else if (wr_go) begin
      unique case (address_in)
        pob_pkg::MASTER_OFF_1: m1_q <= merge(m1_q, pob_pkg::M1_MASK, wmask, wval); // R12
        pob_pkg::MASTER_OFF_2: m2_q <= merge(m2_q, pob_pkg::M2_MASK, wmask, wval);
        pob_pkg::MASTER_OFF_3: m3_q <= merge(m3_q, pob_pkg::M3_MASK, wmask, wval);
        pob_pkg::MASTER_OFF_4: m4_q <= merge(m4_q, pob_pkg::M4_MASK, wmask, wval);
        pob_pkg::MASTER_OFF_6: m6_q <= merge(m6_q, pob_pkg::M6_MASK, wmask, wval);
        pob_pkg::MASTER_OFF_7: m7_q <= merge(m7_q, pob_pkg::M7_MASK, wmask, wval);
        pob_pkg::MASTER_OFF_8: m8_q <= merge(m8_q, pob_pkg::M8_MASK, wmask, wval);
        default: ;
      endcase
    end
  end

  // Slave registers; masks keep reserved bits at zero
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s1_q <= pob_pkg::RESET_VAL; // R11
      s2_q <= pob_pkg::RESET_VAL;
      s4_q <= pob_pkg::RESET_VAL;
      s6_q <= pob_pkg::RESET_VAL;
      s7_q <= pob_pkg::RESET_VAL;
      s8_q <= pob_pkg::RESET_VAL;
    end else if (wr_go) begin
      unique case (address_in)
        pob_pkg::SLAVE_OFF_1: s1_q <= merge(s1_q, pob_pkg::S1_MASK, wmask, wval); // R1 R2 R10
        pob_pkg::SLAVE_OFF_2: s2_q <= merge(s2_q, pob_pkg::S2_MASK, wmask, wval); // R3 R10
        pob_pkg::SLAVE_OFF_4: s4_q <= merge(s4_q, pob_pkg::S4_MASK, wmask, wval); // R4 R10
        pob_pkg::SLAVE_OFF_6: s6_q <= merge(s6_q, pob_pkg::S6_MASK, wmask, wval); // R5 R10
        pob_pkg::SLAVE_OFF_7: s7_q <= merge(s7_q, pob_pkg::S7_MASK, wmask, wval); // R6 R7 R10
        pob_pkg::SLAVE_OFF_8: s8_q <= merge(s8_q, pob_pkg::S8_MASK, wmask, wval); // R8 R9 R10
        default: ;
      endcase
    end
  end

  // Read data and response captured in the wait cycle, stand in the ack cycle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_q <= 32'h0000_0000;
      resp_q  <= pob_pkg::RESP_OKAY;
    end else if (req & ~ack_q) begin
      rdata_q <= read_in ? {16'h0000, sel_val & sel_mask} : 32'h0000_0000; // R10
      resp_q  <= (sel_mask == 16'h0000) ? pob_pkg::RESP_DECODE : pob_pkg::RESP_OKAY;
    end
  end

  assign readdata_out = rdata_q;
  assign response_out = resp_q;

  // Off bits hold each peripheral in reset; restart is from reset state
  assign master_off_1_out = m1_q; // R13
  assign master_off_2_out = m2_q;
  assign master_off_3_out = m3_q;
  assign master_off_4_out = m4_q;
  assign master_off_6_out = m6_q;
  assign master_off_7_out = m7_q;
  assign master_off_8_out = m8_q;
  assign slave_off_1_out  = s1_q; // R13
  assign slave_off_2_out  = s2_q;
  assign slave_off_4_out  = s4_q;
  assign slave_off_6_out  = s6_q;
  assign slave_off_7_out  = s7_q;
  assign slave_off_8_out  = s8_q;

  // Clock enables for the register-1 peripherals; gate cells sit outside
  assign master_clk_en_1_out = pob_pkg::M1_MASK & ~m1_q; // R13
  assign slave_clk_en_1_out  = pob_pkg::S1_MASK & ~s1_q; // R13

  // Checks
  chk_conv_set: assert property (@(posedge clk_in) disable iff (rst_in) // R1
    (wr_go && address_in == pob_pkg::SLAVE_OFF_1 && byteenable_in[0] && writedata_in[0])
    |=> slave_off_1_out[pob_pkg::CONVERTER_OFF] && !slave_clk_en_1_out[0])
    else $error("converter off bit not set by write");

  chk_timer_clr: assert property (@(posedge clk_in) disable iff (rst_in) // R2
    (wr_go && address_in == pob_pkg::SLAVE_OFF_1 && byteenable_in[1] && !writedata_in[11])
    |=> !slave_off_1_out[pob_pkg::TIMER_ONE_OFF])
    else $error("timer off bit not cleared by write");

  chk_capture_write: assert property (@(posedge clk_in) disable iff (rst_in) // R3
    (wr_go && address_in == pob_pkg::SLAVE_OFF_2 && byteenable_in[0])
    |=> slave_off_2_out == ($past(writedata_in[15:0]) & 16'h000f))
    else $error("capture unit bits wrong after write");

  chk_refclk_only: assert property (@(posedge clk_in) disable iff (rst_in) // R4
    (slave_off_4_out & ~16'h0008) == 16'h0000)
    else $error("reference clock register holds stray bits");

  chk_dma_hold: assert property (@(posedge clk_in) disable iff (rst_in) // R5
    !(wr_go && address_in == pob_pkg::SLAVE_OFF_6) |=> $stable(slave_off_6_out))
    else $error("transfer channel bits changed without a write");

  chk_cmp_write: assert property (@(posedge clk_in) disable iff (rst_in) // R6
    (wr_go && address_in == pob_pkg::SLAVE_OFF_7 && byteenable_in[1])
    |=> slave_off_7_out[10:8] == $past(writedata_in[10:8]))
    else $error("comparator bits wrong after write");

  chk_pga1_write: assert property (@(posedge clk_in) disable iff (rst_in) // R7
    (wr_go && address_in == pob_pkg::SLAVE_OFF_7 && byteenable_in[0])
    |=> slave_off_7_out[pob_pkg::GAIN_AMP_1_OFF] == $past(writedata_in[1]))
    else $error("gain amp 1 bit wrong after write");

  chk_pga_clc_write: assert property (@(posedge clk_in) disable iff (rst_in) // R8
    (wr_go && address_in == pob_pkg::SLAVE_OFF_8 && &byteenable_in[1:0])
    |=> slave_off_8_out == ($past(writedata_in[15:0]) & 16'h443c))
    else $error("gain amp or logic cell bits wrong after write");

  chk_clc_reset: assert property (@(posedge clk_in) // R9
    rst_in |=> slave_off_8_out[5:2] == 4'h0)
    else $error("logic cell bits not cleared by reset");

  chk_read_zero: assert property (@(posedge clk_in) disable iff (rst_in) // R10
    (read_in && !ack_q && address_in == pob_pkg::SLAVE_OFF_6)
    ##1 (read_in && !waitrequest_out) |-> readdata_out[31:10] == 22'h0 && readdata_out[7:0] == 8'h00)
    else $error("reserved bits read non-zero");

  chk_reset_clear: assert property (@(posedge clk_in) // R11
    rst_in |=> master_off_1_out == 16'h0000 && slave_off_7_out == 16'h0000
               && slave_clk_en_1_out == 16'h0ea9)
    else $error("registers not cleared by reset");

  chk_master_map: assert property (@(posedge clk_in) disable iff (rst_in) // R12
    (master_off_1_out & 16'hf100) == 16'h0000 && (master_off_3_out & 16'hff7d) == 16'h0000)
    else $error("master register holds unimplemented bits");

  chk_clock_gate: assert property (@(posedge clk_in) disable iff (rst_in) // R13
    master_clk_en_1_out == (16'h0eff & ~master_off_1_out))
    else $error("clock enable disagrees with off bits");

  chk_wait_once: assert property (@(posedge clk_in) disable iff (rst_in)
    ($rose(req) || (req && !$past(req))) |-> waitrequest_out ##1 !waitrequest_out)
    else $error("access not answered after one wait cycle");

  // Lane-wise write checks; expected bits follow the bit maps, not the masks
  chk_conv_clear: assert property (@(posedge clk_in) disable iff (rst_in) // R1
    (wr_go && address_in == pob_pkg::SLAVE_OFF_1 && byteenable_in[0] && !writedata_in[0])
    |=> !slave_off_1_out[0] && slave_clk_en_1_out[0])
    else $error("converter not enabled by write");

  chk_low_lane: assert property (@(posedge clk_in) disable iff (rst_in) // R2
    (wr_go && address_in == pob_pkg::SLAVE_OFF_1 && byteenable_in[0])
    |=> slave_off_1_out[7:0] == ($past(writedata_in[7:0]) & 8'ha9))
    else $error("slave register 1 low byte wrong");

  chk_high_lane: assert property (@(posedge clk_in) disable iff (rst_in) // R2
    (wr_go && address_in == pob_pkg::SLAVE_OFF_1 && byteenable_in[1])
    |=> slave_off_1_out[15:8] == ($past(writedata_in[15:8]) & 8'h0e))
    else $error("slave register 1 high byte wrong");

  chk_capture_spare: assert property (@(posedge clk_in) disable iff (rst_in) // R3
    (slave_off_2_out & 16'hfff0) == 16'h0000)
    else $error("capture register holds stray bits");

  chk_refclk_write: assert property (@(posedge clk_in) disable iff (rst_in) // R4
    (wr_go && address_in == pob_pkg::SLAVE_OFF_4 && byteenable_in[0])
    |=> slave_off_4_out[3] == $past(writedata_in[3]))
    else $error("reference clock bit wrong after write");

  chk_dma_write: assert property (@(posedge clk_in) disable iff (rst_in) // R5
    (wr_go && address_in == pob_pkg::SLAVE_OFF_6 && byteenable_in[1])
    |=> slave_off_6_out == ($past(writedata_in[15:0]) & 16'h0300))
    else $error("transfer channel bits wrong after write");

  chk_cmp_spare: assert property (@(posedge clk_in) disable iff (rst_in) // R6
    (slave_off_7_out & 16'hf8fd) == 16'h0000)
    else $error("comparator register holds stray bits");

  chk_amp1_clear: assert property (@(posedge clk_in) disable iff (rst_in) // R7
    (wr_go && address_in == pob_pkg::SLAVE_OFF_7 && byteenable_in[0] && !writedata_in[1])
    |=> !slave_off_7_out[pob_pkg::GAIN_AMP_1_OFF])
    else $error("gain amp 1 not enabled by write");

  chk_amp_write: assert property (@(posedge clk_in) disable iff (rst_in) // R8
    (wr_go && address_in == pob_pkg::SLAVE_OFF_8 && byteenable_in[1])
    |=> slave_off_8_out[15:8] == ($past(writedata_in[15:8]) & 8'h44))
    else $error("gain amp bits wrong after write");

  chk_amp_spare: assert property (@(posedge clk_in) disable iff (rst_in) // R8
    (slave_off_8_out & 16'hbbc3) == 16'h0000)
    else $error("slave register 8 holds stray bits");

  chk_clc_write: assert property (@(posedge clk_in) disable iff (rst_in) // R9
    (wr_go && address_in == pob_pkg::SLAVE_OFF_8 && byteenable_in[0])
    |=> slave_off_8_out[5:2] == $past(writedata_in[5:2]))
    else $error("logic cell bits wrong after write");

  // Bus answers; a read must never disturb the off bits it reports
  chk_read_upper: assert property (@(posedge clk_in) disable iff (rst_in) // R10
    (read_in && !waitrequest_out) |-> readdata_out[31:16] == 16'h0000)
    else $error("upper read half not zero");

  chk_unmapped_read: assert property (@(posedge clk_in) disable iff (rst_in) // R10
    (read_in && !ack_q && sel_mask == 16'h0000) ##1 (read_in && !waitrequest_out)
    |-> readdata_out == 32'h0000_0000 && response_out == pob_pkg::RESP_DECODE)
    else $error("unmapped read not answered with zero");

  chk_unmapped_write: assert property (@(posedge clk_in) disable iff (rst_in) // R10
    (wr_go && sel_mask == 16'h0000)
    |=> master_off_1_out == $past(master_off_1_out) && slave_off_1_out == $past(slave_off_1_out))
    else $error("unmapped write changed a register");

  chk_read_value: assert property (@(posedge clk_in) disable iff (rst_in) // R11
    (read_in && !ack_q && address_in == pob_pkg::SLAVE_OFF_2) ##1 (read_in && !waitrequest_out)
    |-> readdata_out[15:0] == slave_off_2_out)
    else $error("read data differ from register");

  chk_write_okay: assert property (@(posedge clk_in) disable iff (rst_in) // R11
    (write_in && !ack_q && address_in == pob_pkg::SLAVE_OFF_2) ##1 (write_in && !waitrequest_out)
    |-> response_out == pob_pkg::RESP_OKAY)
    else $error("mapped write not answered okay");

  chk_reset_all: assert property (@(posedge clk_in) // R11
    rst_in |=> slave_off_1_out == 16'h0000 && slave_off_2_out == 16'h0000
               && slave_off_6_out == 16'h0000 && master_off_8_out == 16'h0000)
    else $error("off bits not cleared by reset");

  chk_read_keeps: assert property (@(posedge clk_in) disable iff (rst_in) // R11
    (read_in && !waitrequest_out) |=> slave_off_8_out == $past(slave_off_8_out))
    else $error("read changed a register");

  chk_master_write: assert property (@(posedge clk_in) disable iff (rst_in) // R12
    (wr_go && address_in == pob_pkg::MASTER_OFF_1 && &byteenable_in[1:0])
    |=> master_off_1_out == ($past(writedata_in[15:0]) & 16'h0eff))
    else $error("master register 1 wrong after write");

  chk_master_spare: assert property (@(posedge clk_in) disable iff (rst_in) // R12
    (master_off_2_out & 16'hff00) == 16'h0000 && (master_off_4_out & 16'hfff7) == 16'h0000
    && (master_off_6_out & 16'hc0ff) == 16'h0000 && (master_off_7_out & 16'hfef7) == 16'h0000
    && (master_off_8_out & 16'he7c1) == 16'h0000)
    else $error("master register holds stray bits");

  // Clock enables per peripheral; a gate left running would defeat the hold
  chk_gate_drop: assert property (@(posedge clk_in) disable iff (rst_in) // R13
    (wr_go && address_in == pob_pkg::MASTER_OFF_1 && byteenable_in[0] && writedata_in[0])
    |=> !master_clk_en_1_out[0])
    else $error("converter clock still runs when off");

  chk_gate_release: assert property (@(posedge clk_in) disable iff (rst_in) // R13
    (wr_go && address_in == pob_pkg::SLAVE_OFF_1 && byteenable_in[1] && !writedata_in[11])
    |=> slave_clk_en_1_out[11])
    else $error("timer clock not restarted");

  chk_slave_gate: assert property (@(posedge clk_in) disable iff (rst_in) // R13
    (slave_clk_en_1_out & slave_off_1_out) == 16'h0000
    && (slave_clk_en_1_out | slave_off_1_out) == 16'h0ea9)
    else $error("slave clock enables disagree with off bits");

endmodule : pob_bank
`default_nettype wire

// [logic/pob_pkg.sv]
// Constants for the peripheral module-off register bank.
// Assumes a 32-bit Avalon-MM slave port, byte addresses, one word per register.
// Overview of operation
// R1: Slave register 1 bit 0 powers the converter down when set.
// R2: Slave register 1 bits 11,10,9,7,5,3: timer, decoder, PWM, two-wire, serial, four-wire.
// R3: Slave register 2 bits 3..0 power capture units 4..1 down.
// R4: Slave register 4 bit 3 powers the reference clock output down.
// R5: Slave register 6 bits 9 and 8 power transfer channels 1 and 0 down.
// R6: Slave register 7 bits 10..8 power comparators 3..1 down.
// R7: Slave register 7 bit 1 powers gain amplifier 1 down.
// R8: Slave register 8 bits 14 and 10 power gain amplifiers 3 and 2 down.
// R9: Slave register 8 bits 5..2 power logic cells 4..1 down.
// R10: Bits without a function ignore writes and read as zero.
// R11: Implemented bits are read/write and clear at reset, all peripherals on.
// R12: Master has registers 1,2,3,4,6,7,8; register 1 uses bits 11..0 except 8.
// R13: A set bit stops that peripheral's clock and holds it in reset; clock enables exist only for register 1 of each core.
package pob_pkg;
  localparam int          DATA_W = 16;
  localparam int          IDX_W  = 4;
  // Byte offsets of the registers
  localparam logic [5:0] MASTER_OFF_1 = 6'h00;
  localparam logic [5:0] MASTER_OFF_2 = 6'h04;
  localparam logic [5:0] MASTER_OFF_3 = 6'h08;
  localparam logic [5:0] MASTER_OFF_4 = 6'h0c;
  localparam logic [5:0] MASTER_OFF_6 = 6'h10;
  localparam logic [5:0] MASTER_OFF_7 = 6'h14;
  localparam logic [5:0] MASTER_OFF_8 = 6'h18;
  localparam logic [5:0] SLAVE_OFF_1  = 6'h20;
  localparam logic [5:0] SLAVE_OFF_2  = 6'h24;
  localparam logic [5:0] SLAVE_OFF_4  = 6'h28;
  localparam logic [5:0] SLAVE_OFF_6  = 6'h2c;
  localparam logic [5:0] SLAVE_OFF_7  = 6'h30;
  localparam logic [5:0] SLAVE_OFF_8  = 6'h34;
  // Slave field positions
  localparam int CONVERTER_OFF          = 0;
  localparam int FOUR_WIRE_PORT_ONE_OFF = 3;
  localparam int SERIAL_PORT_ONE_OFF    = 5;
  localparam int TWO_WIRE_PORT_ONE_OFF  = 7;
  localparam int PULSE_WIDTH_UNIT_OFF   = 9;
  localparam int QUADRATURE_DECODER_OFF = 10;
  localparam int TIMER_ONE_OFF          = 11;
  localparam int CAPTURE_UNIT_1_OFF     = 0;
  localparam int REFERENCE_CLOCK_OUT_OFF = 3;
  localparam int TRANSFER_CHANNEL_0_OFF = 8;
  localparam int COMPARATOR_1_OFF       = 8;
  localparam int GAIN_AMP_1_OFF         = 1;
  localparam int GAIN_AMP_2_OFF         = 10;
  localparam int GAIN_AMP_3_OFF         = 14;
  localparam int LOGIC_CELL_1_OFF       = 2;
  // Implemented-bit masks; everything else reads zero
  localparam logic [15:0] M1_MASK = 16'h0eff;
  localparam logic [15:0] M2_MASK = 16'h00ff;
  localparam logic [15:0] M3_MASK = 16'h0082;
  localparam logic [15:0] M4_MASK = 16'h0008;
  localparam logic [15:0] M6_MASK = 16'h3f00;
  localparam logic [15:0] M7_MASK = 16'h0108;
  localparam logic [15:0] M8_MASK = 16'h183e;
  localparam logic [15:0] S1_MASK = 16'h0ea9;
  localparam logic [15:0] S2_MASK = 16'h000f;
  localparam logic [15:0] S4_MASK = 16'h0008;
  localparam logic [15:0] S6_MASK = 16'h0300;
  localparam logic [15:0] S7_MASK = 16'h0702;
  localparam logic [15:0] S8_MASK = 16'h443c;
  localparam logic [15:0] RESET_VAL = 16'h0000;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_DECODE = 2'h3;
endpackage : pob_pkg

// [testbench/tb.sv]
// Self-checking bench for the peripheral module-off register bank.
// Assumes pob_pkg and pob_bank are compiled first; the bench is the Avalon master.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk_in        = 1'b0;
  logic        rst_in        = 1'b1;
  logic [5:0]  address_in    = 6'h00;
  logic        read_in       = 1'b0;
  logic        write_in      = 1'b0;
  logic [31:0] writedata_in  = 32'h00000000;
  logic [3:0]  byteenable_in = 4'hf;
  logic [31:0] readdata_out;
  logic [1:0]  response_out;
  logic        waitrequest_out;
  logic [15:0] off_w [13];
  logic [15:0] m_en_w;
  logic [15:0] s_en_w;
  int          mismatches  = 0;
  int          check_count = 0;
  int          cycles      = 0;
  // Register table: master 1,2,3,4,6,7,8 then slave 1,2,4,6,7,8
  logic [5:0]  addr_t [13] = '{pob_pkg::MASTER_OFF_1, pob_pkg::MASTER_OFF_2,
    pob_pkg::MASTER_OFF_3, pob_pkg::MASTER_OFF_4, pob_pkg::MASTER_OFF_6, pob_pkg::MASTER_OFF_7,
    pob_pkg::MASTER_OFF_8, pob_pkg::SLAVE_OFF_1, pob_pkg::SLAVE_OFF_2, pob_pkg::SLAVE_OFF_4,
    pob_pkg::SLAVE_OFF_6, pob_pkg::SLAVE_OFF_7, pob_pkg::SLAVE_OFF_8};
  // Implemented bits written out independently of the package masks
  logic [15:0] mask_t [13] = '{16'h0eff, 16'h00ff, 16'h0082, 16'h0008, 16'h3f00, 16'h0108,
    16'h183e, 16'h0ea9, 16'h000f, 16'h0008, 16'h0300, 16'h0702, 16'h443c};

  pob_bank u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .address_in(address_in), .read_in(read_in),
    .write_in(write_in), .writedata_in(writedata_in), .byteenable_in(byteenable_in),
    .readdata_out(readdata_out), .response_out(response_out),
    .waitrequest_out(waitrequest_out), .master_off_1_out(off_w[0]),
    .master_off_2_out(off_w[1]), .master_off_3_out(off_w[2]), .master_off_4_out(off_w[3]),
    .master_off_6_out(off_w[4]), .master_off_7_out(off_w[5]), .master_off_8_out(off_w[6]),
    .slave_off_1_out(off_w[7]), .slave_off_2_out(off_w[8]), .slave_off_4_out(off_w[9]),
    .slave_off_6_out(off_w[10]), .slave_off_7_out(off_w[11]), .slave_off_8_out(off_w[12]),
    .master_clk_en_1_out(m_en_w), .slave_clk_en_1_out(s_en_w));

  always #5 clk_in = ~clk_in;

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk_in) begin
    cycles = cycles + 1;
    if (cycles == 4000) begin
      mismatches = mismatches + 1;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One Avalon access, entered just after a rising edge; data taken at the edge
  // where waitrequest is low, and only the hang guard ends a wait
  task automatic bus(input logic wr, input logic [5:0] a, input logic [15:0] d,
                     input logic [3:0] be, output logic [31:0] rd, output logic [1:0] rs);
    address_in    <= a;
    writedata_in  <= {16'h0000, d};
    byteenable_in <= be;
    write_in      <= wr;
    read_in       <= ~wr;
    @(posedge clk_in);
    while (waitrequest_out !== 1'b0) @(posedge clk_in);
    rd = readdata_out;
    rs = response_out;
    write_in <= 1'b0;
    read_in  <= 1'b0;
    // A free edge keeps the next request from reassigning in the same step
    @(posedge clk_in);
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [15:0] d, input logic [3:0] be);
    logic [31:0] rd;
    logic [1:0]  rs;
    bus(1'b1, a, d, be, rd, rs);
    chk({30'h0, rs}, {30'h0, pob_pkg::RESP_OKAY});
  endtask : wr

  task automatic rdc(input logic [5:0] a, input logic [15:0] exp, input logic [1:0] er);
    logic [31:0] rd;
    logic [1:0]  rs;
    bus(1'b0, a, 16'h0000, 4'hf, rd, rs);
    chk(rd, {16'h0000, exp});
    chk({30'h0, rs}, {30'h0, er});
  endtask : rdc

  task automatic t_reset();
    for (int i = 0; i < 13; i++) begin
      rdc(addr_t[i], 16'h0000, pob_pkg::RESP_OKAY);
      chk({16'h0, off_w[i]}, 32'h0);
    end
    chk({16'h0, m_en_w}, 32'h0eff);
    chk({16'h0, s_en_w}, 32'h0ea9);
    $display("test reset values done");
  endtask : t_reset

  // All ones then all zeros: only the documented bits stick and drive the holds
  task automatic t_ones();
    for (int i = 0; i < 13; i++) begin
      wr(addr_t[i], 16'hffff, 4'hf);
      rdc(addr_t[i], mask_t[i], pob_pkg::RESP_OKAY);
      chk({16'h0, off_w[i]}, {16'h0, mask_t[i]});
    end
    chk({16'h0, m_en_w}, 32'h0);
    chk({16'h0, s_en_w}, 32'h0);
    for (int i = 0; i < 13; i++) begin
      wr(addr_t[i], 16'h0000, 4'hf);
      rdc(addr_t[i], 16'h0000, pob_pkg::RESP_OKAY);
    end
    chk({16'h0, s_en_w}, 32'h0ea9);
    $display("test ones and zeros done");
  endtask : t_ones

  // Single bits through slave register 1, watching each clock gate on its own
  task automatic t_walk();
    logic [15:0] b;
    for (int k = 0; k < 16; k++) begin
      b = 16'h0001 << k;
      wr(pob_pkg::SLAVE_OFF_1, b, 4'hf);
      rdc(pob_pkg::SLAVE_OFF_1, b & 16'h0ea9, pob_pkg::RESP_OKAY);
      chk({16'h0, s_en_w}, {16'h0, 16'h0ea9 & ~b});
    end
    wr(pob_pkg::SLAVE_OFF_1, 16'h0000, 4'hf);
    $display("test walking bits done");
  endtask : t_walk

  // Byte lanes write one half at a time
  task automatic t_lanes();
    wr(pob_pkg::SLAVE_OFF_8, 16'hffff, 4'h1);
    rdc(pob_pkg::SLAVE_OFF_8, 16'h003c, pob_pkg::RESP_OKAY);
    wr(pob_pkg::SLAVE_OFF_8, 16'hffff, 4'h2);
    rdc(pob_pkg::SLAVE_OFF_8, 16'h443c, pob_pkg::RESP_OKAY);
    wr(pob_pkg::SLAVE_OFF_8, 16'h0000, 4'h1);
    rdc(pob_pkg::SLAVE_OFF_8, 16'h4400, pob_pkg::RESP_OKAY);
    $display("test byte lanes done");
  endtask : t_lanes

  // Unmapped and misaligned places answer a decode error and change nothing
  task automatic t_unmapped();
    logic [31:0] rd;
    logic [1:0]  rs;
    bus(1'b1, 6'h38, 16'hffff, 4'hf, rd, rs);
    chk({30'h0, rs}, {30'h0, pob_pkg::RESP_DECODE});
    bus(1'b1, 6'h21, 16'hffff, 4'hf, rd, rs);
    chk({30'h0, rs}, {30'h0, pob_pkg::RESP_DECODE});
    rdc(6'h38, 16'h0000, pob_pkg::RESP_DECODE);
    rdc(6'h21, 16'h0000, pob_pkg::RESP_DECODE);
    rdc(pob_pkg::SLAVE_OFF_1, 16'h0000, pob_pkg::RESP_OKAY);
    rdc(pob_pkg::MASTER_OFF_1, 16'h0000, pob_pkg::RESP_OKAY);
    $display("test unmapped done");
  endtask : t_unmapped

  // Reset in mid-run clears every hold again
  task automatic t_midreset();
    for (int i = 0; i < 13; i++) wr(addr_t[i], 16'hffff, 4'hf);
    rst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    for (int i = 0; i < 13; i++) chk({16'h0, off_w[i]}, 32'h0);
    rdc(pob_pkg::SLAVE_OFF_8, 16'h0000, pob_pkg::RESP_OKAY);
    chk({16'h0, m_en_w}, 32'h0eff);
    $display("test mid-run reset done");
  endtask : t_midreset

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  initial begin
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    t_reset();
    t_ones();
    t_walk();
    t_lanes();
    t_unmapped();
    t_midreset();
    test_done();
  end
endmodule : tb
`default_nettype wire
